// ===== hdl/flash_host_regs.svh
/*
  Register offsets, field positions, reset values and pin timings in nanoseconds of the flash bus controller.
  Assumes inclusion by bare name from the controller file.
*/
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
`define OFF_CTRL        12'h000
`define OFF_ADDR        12'h004
`define OFF_WDATA       12'h008
`define OFF_RDATA       12'h00C
`define OFF_STATUS      12'h010
`define OFF_POLL        12'h014
`define CTRL_GO         0
`define CTRL_WRITE      1
`define CTRL_POLL       2
`define CTRL_BYTE_N     3
`define CTRL_WP_N       4
`define CTRL_RESET      5
`define CTRL_PAGE       6
`define PAGE_BITS       3
`define CTRL_RST_VAL    32'h0000_0018
`define ST_BUSY         0
`define ST_ERROR        1
`define ST_ABORT        2
`define ST_TIMEOUT      3
`define ST_RDY          4
`define BIT_POLL        7
`define BIT_TOGGLE      6
`define BIT_ERR         5
`define BIT_ABORT       1
`define ACCESS_NS       70
`define PAGE_NS         25
`define SETUP_NS        10
`define RESET_NS        500
`define CLK_NS          10
`endif

// ===== hdl/flash_host_pkg.sv
/*
  Types shared by the flash bus controller.
  Assumes the register header defines the constants used with these types.
*/
package flash_host_pkg;
  typedef enum logic [3:0] {
    S_IDLE,
    S_RST,
    S_SETUP,
    S_RD_WAIT,
    S_WR_LOW,
    S_WR_HIGH,
    S_RECOVER,
    S_POLL_A,
    S_POLL_B,
    S_DONE
  } bus_state_e;
endpackage

// ===== hdl/flash_host.sv
/*
  APB-controlled host for an asynchronous parallel NOR flash: drives chip select, output enable,
  write enable, reset, write protect and byte select, performs read, write and status-poll cycles.
  Assumes the flash pins are wired straight out, and data lines come back through a two-stage synchroniser.
*/
// Functional notes
// - Read cycle: chip select and output enable low, write enable high, reset high.
// - Host holds output enable high throughout every write cycle.
// - After an error the host must issue read/reset before other commands; the controller accepts any command and leaves that order to software.
// - Abort bit set on buffer abort; host issues abort-and-reset command; the controller only sets the abort status bit and issues no command itself.
`timescale 1ns/1ps
`include "flash_host_regs.svh"

module flash_host #(
  parameter int ADDR_W    = 22,
  parameter int POLL_MAX  = 100000
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [ADDR_W-1:0]       flash_addr,
  output logic                    chip_sel_n,
  output logic                    out_en_n,
  output logic                    wr_en_n,
  output logic                    flash_rst_n,
  output logic                    wr_prot_n,
  output logic                    byte_mode_n,
  output logic [15:0]             data_out,
  output logic                    data_oe,
  input  wire logic [15:0]        data_in,
  input  wire logic               ready_busy_n
);
  localparam int ACC_CYC  = (`ACCESS_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int PAGE_CYC = (`PAGE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int SET_CYC  = (`SETUP_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int RST_CYC  = (`RESET_NS + `CLK_NS - 1) / `CLK_NS;

  flash_host_pkg::bus_state_e state_r, state_nxt;
  logic [31:0]       ctrl_r, ctrl_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [15:0]       wdata_r, wdata_nxt;
  logic [15:0]       rdata_r, rdata_nxt;
  logic [4:0]        status_r, status_nxt;
  logic [15:0]       poll_prev_r, poll_prev_nxt;
  logic [7:0]        cnt_r, cnt_nxt;
  logic [31:0]       pcount_r, pcount_nxt;
  logic [ADDR_W-1:0] last_addr_r, last_addr_nxt;
  logic              page_ok_r, page_ok_nxt;
  logic [15:0]       din_meta_r, din_sync_r;
  logic [1:0]        rb_sync_r;

  logic wr_acc;
  logic rd_acc;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
    is_reg = (a == off);
  endfunction

  // Pin data crosses into the clock domain through two flops before any use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_meta_r <= 16'h0000;
      din_sync_r <= 16'h0000;
      rb_sync_r  <= 2'h0;
    end else begin
      din_meta_r <= data_in;
      din_sync_r <= din_meta_r;
      rb_sync_r  <= {rb_sync_r[0], ready_busy_n};
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      if (is_reg(paddr, `OFF_CTRL))
        prdata = ctrl_r;
      else if (is_reg(paddr, `OFF_ADDR))
        prdata = 32'(addr_r);
      else if (is_reg(paddr, `OFF_WDATA))
        prdata = {16'h0000, wdata_r};
      else if (is_reg(paddr, `OFF_RDATA))
        prdata = {16'h0000, rdata_r};
      else if (is_reg(paddr, `OFF_STATUS))
        prdata = {27'h0000000, status_r};
      else if (is_reg(paddr, `OFF_POLL))
        prdata = pcount_r;
    end
  end

  always_comb begin
    logic go;
    logic same_page;
    go            = 1'b0;
    same_page     = 1'b0;
    state_nxt     = state_r;
    ctrl_nxt      = ctrl_r;
    addr_nxt      = addr_r;
    wdata_nxt     = wdata_r;
    rdata_nxt     = rdata_r;
    status_nxt    = status_r;
    poll_prev_nxt = poll_prev_r;
    cnt_nxt       = cnt_r;
    pcount_nxt    = pcount_r;
    last_addr_nxt = last_addr_r;
    page_ok_nxt   = page_ok_r;
    status_nxt[`ST_RDY] = rb_sync_r[1];
    if (wr_acc && is_reg(paddr, `OFF_CTRL)) begin
      ctrl_nxt = pwdata;
      go       = pwdata[`CTRL_GO] && !status_r[`ST_BUSY];
    end
    if (wr_acc && is_reg(paddr, `OFF_ADDR))
      addr_nxt = pwdata[ADDR_W-1:0];
    if (wr_acc && is_reg(paddr, `OFF_WDATA))
      wdata_nxt = pwdata[15:0];
    ctrl_nxt[`CTRL_GO] = 1'b0;
    // The page enable is taken from the command word itself, as the go write lands in the same cycle.
    same_page = page_ok_r && pwdata[`CTRL_PAGE] &&
                (addr_r[ADDR_W-1:`PAGE_BITS] == last_addr_r[ADDR_W-1:`PAGE_BITS]);
    unique case (state_r)
      flash_host_pkg::S_IDLE: begin
        if (ctrl_r[`CTRL_RESET]) begin
          state_nxt  = flash_host_pkg::S_RST;
          cnt_nxt    = 8'(RST_CYC);
          ctrl_nxt[`CTRL_RESET] = 1'b0;
          page_ok_nxt = 1'b0;
          status_nxt[`ST_BUSY] = 1'b1;
        end else if (go) begin
          status_nxt[`ST_BUSY] = 1'b1;
          status_nxt[`ST_TIMEOUT] = 1'b0;
          pcount_nxt = 32'h0000_0000;
          if (pwdata[`CTRL_WRITE]) begin
            // A command write may follow an error only if it is read/reset; software owns that order.
            status_nxt[`ST_ERROR] = 1'b0;
            status_nxt[`ST_ABORT] = 1'b0;
            page_ok_nxt = 1'b0;
            state_nxt = flash_host_pkg::S_SETUP;
            cnt_nxt   = 8'(SET_CYC);
          end else begin
            state_nxt = flash_host_pkg::S_RD_WAIT;
            cnt_nxt   = same_page ? 8'(PAGE_CYC) : 8'(ACC_CYC);
          end
        end
      end
      flash_host_pkg::S_RST: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          state_nxt = flash_host_pkg::S_DONE;
        end
      end
      flash_host_pkg::S_SETUP: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          state_nxt = flash_host_pkg::S_WR_LOW;
          cnt_nxt   = 8'(ACC_CYC);
        end
      end
      flash_host_pkg::S_WR_LOW: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          state_nxt = flash_host_pkg::S_WR_HIGH;
          cnt_nxt   = 8'(SET_CYC);
        end
      end
      flash_host_pkg::S_WR_HIGH: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          if (ctrl_r[`CTRL_POLL]) begin
            state_nxt = flash_host_pkg::S_RECOVER;
            cnt_nxt   = 8'(ACC_CYC);
          end else begin
            state_nxt = flash_host_pkg::S_DONE;
          end
        end
      end
      flash_host_pkg::S_RECOVER: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          state_nxt = flash_host_pkg::S_POLL_A;
          cnt_nxt   = 8'(ACC_CYC);
        end
      end
      flash_host_pkg::S_RD_WAIT: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          // Synchroniser delay means done stores the data seen in the second-last wait cycle.
          state_nxt     = flash_host_pkg::S_DONE;
          last_addr_nxt = addr_r;
          page_ok_nxt   = 1'b1;
        end
      end
      flash_host_pkg::S_POLL_A: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          poll_prev_nxt = din_sync_r;
          state_nxt     = flash_host_pkg::S_POLL_B;
          cnt_nxt       = 8'(ACC_CYC);
        end
      end
      flash_host_pkg::S_POLL_B: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          rdata_nxt  = din_sync_r;
          pcount_nxt = pcount_r + 32'h0000_0001;
          cnt_nxt    = 8'(ACC_CYC);
          if (din_sync_r[`BIT_TOGGLE] == poll_prev_r[`BIT_TOGGLE]) begin
            state_nxt = flash_host_pkg::S_DONE;
          end else if (din_sync_r[`BIT_ERR] || din_sync_r[`BIT_ABORT]) begin
            // Error and abort end the poll at once, with no further toggle check.
            status_nxt[`ST_ERROR] = din_sync_r[`BIT_ERR];
            status_nxt[`ST_ABORT] = din_sync_r[`BIT_ABORT];
            state_nxt = flash_host_pkg::S_DONE;
          end else if (pcount_r == 32'(POLL_MAX)) begin
            status_nxt[`ST_TIMEOUT] = 1'b1;
            state_nxt = flash_host_pkg::S_DONE;
          end else begin
            poll_prev_nxt = din_sync_r;
          end
        end
      end
      flash_host_pkg::S_DONE: begin
        status_nxt[`ST_BUSY] = 1'b0;
        state_nxt = flash_host_pkg::S_IDLE;
        if (ctrl_r[`CTRL_WRITE] == 1'b0 && !ctrl_r[`CTRL_RESET])
          rdata_nxt = din_sync_r;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= flash_host_pkg::S_IDLE;
      ctrl_r      <= `CTRL_RST_VAL;
      addr_r      <= '0;
      wdata_r     <= 16'h0000;
      rdata_r     <= 16'h0000;
      status_r    <= 5'h00;
      poll_prev_r <= 16'h0000;
      cnt_r       <= 8'h00;
      pcount_r    <= 32'h0000_0000;
      last_addr_r <= '0;
      page_ok_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      ctrl_r      <= ctrl_nxt;
      addr_r      <= addr_nxt;
      wdata_r     <= wdata_nxt;
      rdata_r     <= rdata_nxt;
      status_r    <= status_nxt;
      poll_prev_r <= poll_prev_nxt;
      cnt_r       <= cnt_nxt;
      pcount_r    <= pcount_nxt;
      last_addr_r <= last_addr_nxt;
      page_ok_r   <= page_ok_nxt;
    end
  end

  // Pin drivers are registered so no strobe can glitch between states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_sel_n  <= 1'b1;
      out_en_n    <= 1'b1;
      wr_en_n     <= 1'b1;
      flash_rst_n <= 1'b0;
      wr_prot_n   <= 1'b1;
      byte_mode_n <= 1'b1;
      data_out    <= 16'h0000;
      data_oe     <= 1'b0;
      flash_addr  <= '0;
    end else begin
      flash_rst_n <= (state_nxt != flash_host_pkg::S_RST);
      wr_prot_n   <= ctrl_nxt[`CTRL_WP_N];
      byte_mode_n <= ctrl_nxt[`CTRL_BYTE_N];
      flash_addr  <= addr_nxt;
      // Chip select frames the whole cycle; write enable falls later and rises first.
      chip_sel_n  <= !(state_nxt inside {flash_host_pkg::S_SETUP, flash_host_pkg::S_WR_LOW,
                                         flash_host_pkg::S_WR_HIGH, flash_host_pkg::S_RD_WAIT,
                                         flash_host_pkg::S_POLL_A, flash_host_pkg::S_POLL_B});
      wr_en_n     <= (state_nxt != flash_host_pkg::S_WR_LOW);
      // Output enable stays high throughout writes; reads lower it.
      // A poll lifts output enable in its last cycle, so each sample is a read of its own.
      out_en_n    <= !(state_nxt == flash_host_pkg::S_RD_WAIT ||
                       (state_nxt inside {flash_host_pkg::S_POLL_A, flash_host_pkg::S_POLL_B} &&
                        cnt_nxt != 8'h01));
      data_oe     <= state_nxt inside {flash_host_pkg::S_SETUP, flash_host_pkg::S_WR_LOW,
                                       flash_host_pkg::S_WR_HIGH};
      data_out    <= wdata_nxt;
    end
  end
endmodule

// ===== verif/flash_host_checker.sv
/*
  Concurrent checks on the flash bus controller's APB and flash pins.
  Assumes it is bound to the controller and sees only its ports.
*/
`timescale 1ns/1ps
module flash_host_checker #(
  parameter int ADDR_W   = 22,
  parameter int POLL_MAX = 100000
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              chip_sel_n,
  input wire logic              out_en_n,
  input wire logic              wr_en_n,
  input wire logic              flash_rst_n,
  input wire logic              data_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence we_low_seven;
    (!wr_en_n)[*7] ##1 wr_en_n;
  endsequence
  sequence cs_tail;
    !chip_sel_n ##1 chip_sel_n;
  endsequence
  apb_ready_a: assert property (psel && penable |-> pready) else $error("pready low in access phase");
  write_oe_high_a: assert property (!wr_en_n |-> out_en_n && data_oe) else $error("oe low or data off in write");
  we_pulse_a: assert property ($fell(wr_en_n) |-> we_low_seven) else $error("write strobe width wrong");
  we_setup_a: assert property ($fell(wr_en_n) |-> $past(!chip_sel_n)) else $error("no select before strobe");
  cs_hold_a: assert property ($rose(wr_en_n) |-> cs_tail) else $error("select not held after strobe");
  addr_hold_a: assert property (!chip_sel_n && !$fell(chip_sel_n) |-> $stable(flash_addr))
    else $error("address moved in cycle");
  read_cycle_a: assert property ($fell(out_en_n) |-> (!out_en_n && !chip_sel_n && wr_en_n)[*3])
    else $error("read cycle malformed");
  read_no_drive_a: assert property (!out_en_n |-> !data_oe) else $error("host drives during read");
  unmapped_zero_a: assert property (psel && penable && !pwrite && paddr == 12'h018 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (disable iff (1'b0) !presetn && $past(!presetn) |-> !flash_rst_n && chip_sel_n && !data_oe)
    else $error("pins active in reset");
endmodule

// ===== verif/flash_model.sv
/*
  Behavioural parallel flash: latches commands on strobe edges, answers reads, reports status while busy.
  Assumes the bench feeds the host's drive and enable and takes the resolved data bus.
*/
`timescale 1ns/1ps
module flash_model #(
  parameter int BUSY_READS = 3
) (
  input  wire logic [21:0] addr,
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic [15:0] host_dq,
  input  wire logic        host_oe,
  input  wire logic [1:0]  err_mode,
  output logic      [15:0] bus,
  output logic             ready_busy_n,
  output logic      [21:0] cap_addr,
  output logic      [15:0] cap_data
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q;
  logic [15:0] drv;
  logic        tog;
  int          busy;
  wire         rd_on = rst_n && !cs_n && !oe_n && we_n;
  // Idle reads are single random accesses whose data stands as long as the address is held.
  assign drv = (busy > 0) ? {8'h00, ~cap_data[7], tog, err_mode[0], 3'h0, err_mode[1], 1'b0}
                          : mem[addr[7:0]];
  // A released bus shows the inverse of its last value, so a late sample cannot pass by luck.
  assign bus = host_oe ? host_dq : rd_on ? drv : ~last_q;
  assign ready_busy_n = (busy == 0);
  initial begin
    last_q = 16'h0000;
    tog = 1'b0;
    busy = 0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  always @(bus) if (host_oe || rd_on) last_q = bus;
  always @(negedge we_n) if (!cs_n && rst_n) cap_addr = addr;
  always @(negedge cs_n) if (!we_n && rst_n) cap_addr = addr;
  always @(posedge we_n or posedge cs_n) if (rst_n && (cs_n ^ we_n)) begin
    cap_data = bus;
    mem[cap_addr[7:0]] = bus;
    busy = BUSY_READS;
    tog = 1'b0;
  end
  always @(posedge oe_n) if (busy > 0 && we_n && rst_n) begin
    busy--;
    tog = ~tog;
  end
  always @(negedge rst_n) busy = 0;
endmodule

// ===== verif/testbench.sv
/*
  Self-checking bench for the flash bus controller with a behavioural flash on its pins.
  Assumes the controller answers APB with no wait states and the model sits in this file's top.
*/
`timescale 1ns/1ps
module testbench;
  localparam int ADDR_W   = 22;
  localparam int POLL_MAX = 20;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, ready_busy_n;
  logic              chip_sel_n, out_en_n, wr_en_n, flash_rst_n, wr_prot_n, byte_mode_n, data_oe;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [ADDR_W-1:0] flash_addr, cap_addr;
  logic [15:0]       data_out, dq, cap_data;
  logic [1:0]        err_mode;
  int                errors, checks_done;
  int                oe_low;
  flash_host #(.ADDR_W(ADDR_W), .POLL_MAX(POLL_MAX)) u_flash_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_en_n(wr_en_n), .flash_rst_n(flash_rst_n), .wr_prot_n(wr_prot_n),
    .byte_mode_n(byte_mode_n), .data_out(data_out), .data_oe(data_oe), .data_in(dq),
    .ready_busy_n(ready_busy_n));
  flash_model u_flash_model (.addr(flash_addr), .cs_n(chip_sel_n), .oe_n(out_en_n), .we_n(wr_en_n),
    .rst_n(flash_rst_n), .host_dq(data_out), .host_oe(data_oe), .err_mode(err_mode), .bus(dq),
    .ready_busy_n(ready_busy_n), .cap_addr(cap_addr), .cap_data(cap_data));
  // Counts clocks with output enable low, so a scenario can measure the length of its read.
  always @(posedge pclk) if (out_en_n === 1'b0) oe_low <= oe_low + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h010, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    chk({31'h0, rd[0]}, 32'h0);
  endtask
  task automatic start(input logic [11:0] a, input logic [15:0] d, input logic [31:0] ctrl);
    apb(1'b1, 12'h004, {20'h0, a});
    apb(1'b1, 12'h008, {16'h0, d});
    apb(1'b1, 12'h000, ctrl);
    wait_idle;
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_0018);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0);
    chk({30'h0, byte_mode_n, wr_prot_n}, 32'h3);
  endtask
  task automatic t_prog;
    start(12'h025, 16'h1234, 32'h1F);
    chk({10'h0, cap_addr}, 32'h25);
    chk({16'h0, cap_data}, 32'h1234);
    apb(1'b0, 12'h010, 32'h0);
    chk({28'h0, rd[4:1]}, 32'h8);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0000_0003);
  endtask
  task automatic t_read(input logic [11:0] a, input logic [31:0] ctrl, input logic [31:0] exp, input int cyc);
    int n0;
    n0 = oe_low;
    start(a, 16'h0, ctrl);
    chk(32'(oe_low - n0), 32'(cyc));
    apb(1'b0, 12'h00C, 32'h0);
    chk({16'h0, rd[15:0]}, exp);
  endtask
  task automatic t_pins;
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge pclk);
    chk({30'h0, byte_mode_n, wr_prot_n}, 32'h0);
    apb(1'b1, 12'h000, 32'h18);
  endtask
  task automatic t_err;
    for (int m = 1; m < 3; m++) begin
      err_mode <= 2'(m);
      start(12'h040, 16'h00FF, 32'h1F);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd & 32'h6, 32'(m) << 1);
    end
    err_mode <= 2'b00;
  endtask
  task automatic t_rst;
    int n;
    n = 0;
    apb(1'b1, 12'h000, 32'h38);
    while (flash_rst_n !== 1'b0 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (flash_rst_n === 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n), 32'h0000_0032);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #200us;
    errors++;
    tally_and_finish;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, err_mode} = '0;
    errors = 0;
    checks_done = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_prog;
    t_read(12'h025, 32'h19, 32'h1234, 7);
    t_read(12'h026, 32'h59, 32'h0, 3);
    t_read(12'h025, 32'h59, 32'h1234, 3);
    t_pins;
    t_err;
    t_rst;
    tally_and_finish;
  end
endmodule
bind flash_host flash_host_checker #(.ADDR_W(ADDR_W), .POLL_MAX(POLL_MAX)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .flash_addr(flash_addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
  .wr_en_n(wr_en_n), .flash_rst_n(flash_rst_n), .data_oe(data_oe));
